// *** rtl/txcfg_pkg.sv ***
// constants, register map and types of the transmit configuration block
package txcfg_pkg;
  localparam int NREG = 16;
  localparam int R_BAND = 0;
  localparam int R_SW0 = 1;
  localparam int R_SW1 = 2;
  localparam int R_SW2 = 3;
  localparam int R_THR = 4;
  localparam int R_CTRL = 5;
  localparam int R_RTS = 6;
  localparam int R_TMO = 7;
  localparam int R_RTY = 8;
  localparam int R_LINK = 9;
  localparam int R_HT0 = 10;
  localparam int R_HT1 = 11;
  localparam int R_LG0 = 12;
  localparam int R_LG1 = 13;
  localparam int R_CCK = 14;
  localparam int R_PIN = 15;
  localparam logic [NREG-1:0][15:0] REG_OFF = {
    16'h1328, 16'h1364, 16'h1360, 16'h135C, 16'h1358, 16'h1354, 16'h1350, 16'h134C,
    16'h1348, 16'h1344, 16'h1340, 16'h133C, 16'h1338, 16'h1334, 16'h1330, 16'h132C};
  localparam logic [15:0] STAT_OFF = 16'h13FC;
  localparam logic [NREG-1:0][31:0] REG_RST = {
    32'h00050F0F, 32'h00100003, 32'h00002100, 32'hEDCBA988,
    32'hEDCBA988, 32'h65432100, 32'h7F7F0020, 32'h2BB80407,
    32'h000F0A90, 32'h00FFFF07, 32'h0000243F, 32'h00000000,
    32'h000C0408, 32'h000C0808, 32'h0004080C, 32'h00000004};
  localparam logic [NREG-1:0][31:0] WMASK = {
    32'h000FFFFF, 32'h07FFFFFF, 32'h0000FFFF, 32'hFFFFFFFF,
    32'hFFFFFFFF, 32'hFFFFFFFF, 32'h00001FFF, 32'h7FFFFFFF,
    32'h00FFFFF0, 32'h01FFFFFF, 32'h000FFFFF, 32'hFFFFFFFF,
    32'hFFFFFFFF, 32'h00FFFFFF, 32'hFFFFFFFF, 32'h00000007};
  localparam logic [31:0] LINK_RO = 32'hFFFF0000;
  localparam int SUBBAND_BIT = 0;
  localparam int HB_TRUE_BIT = 1;
  localparam int HB_INV_BIT = 2;
  localparam int EXT_EN_BIT = 7;
  localparam int AUTOFB_BIT = 30;
  localparam int AGG_MODE_BIT = 29;
  localparam int SGL_MODE_BIT = 28;
  localparam int RF_EN_BIT = 16;
  localparam int RF_POL_BIT = 17;
  localparam int SW_EN_BIT = 18;
  localparam int SW_POL_BIT = 19;
  localparam int NCH = 6;
  localparam int CH_RF = 0;
  localparam int CH_SW = 1;
  localparam int CH_PA = 2;
  localparam int CH_DAC = 3;
  localparam int CH_LNA = 4;
  localparam int CH_TXPE = 5;
  localparam int CLK_NS = 4;
  localparam int QUARTER_NS = 250;
  localparam int US_NS = 1000;
  localparam int US_CYC = US_NS / CLK_NS;
  localparam int UNIT32_SHIFT = 5;
  localparam int LIFE_BASE = 9;
  localparam logic [7:0] RELEASE_OFF = 8'hFF;
  typedef enum logic [1:0] {SEQ_IDLE, SEQ_ON, SEQ_OFF} seq_t;
endpackage : txcfg_pkg

// *** rtl/wlan_mac_tx_config.sv ***
// transmit configuration registers, rf front-end sequencer and transmit policy decisions
//
// Our own choice: the APB slave port.
`timescale 1ns/1ns
`default_nettype none
// How it works
// - amp and lna pins drive only when enabled; polarity bit flips the active level
// - sub-band choice 0 uses lower half, 1 the upper half
// - sub-band choice counts only while baseband is set to 40 MHz
// - two software pins for high band, true resets 0, inverse resets 1
// - at transmit start four lines rise, each after its own quarter-us delay
// - after transmit end three lines fall, each after its own quarter-us delay
// - baseband transmit enable drops once the last byte is handed over
// - lna and converter lines have their own rise and fall delays
// - remaining opportunity below limit times 32 us lapses silently
// - remaining above release limit sends release frame; 0xFF disables it
// - reverse grant usable when received duration reaches its limit
// - reverse grant bit allowed when remaining reaches transmit limit
// - extension sensing defers 40 MHz or falls back to 20 MHz
// - delayed copy of extension sensing, delay in microseconds
// - truncation mask enables each truncation cause separately
// - frames over the length limit need protection; retries up to limit
// - queued frame expires after 2 to the power 9 plus exponent us
// - per frame kind, retry end by retry count or by lifetime
// - long frames use long retry limit, others the short limit
// - fallback rate from table; equal to current rate means stop
// - high-throughput rates never fall back to legacy rates
// - bit 3 of a legacy fallback field picks cck or ofdm
module wlan_mac_tx_config
  import txcfg_pkg::*;
(
  input  wire logic        pclk,              // bus clock, 250 MHz
  input  wire logic        presetn,           // async reset
  input  wire logic        psel,              // apb select
  input  wire logic        penable,           // apb enable
  input  wire logic        pwrite,            // apb direction
  input  wire logic [15:0] paddr,             // apb byte address
  input  wire logic [31:0] pwdata,            // apb write data
  output logic             pready,            // apb ready
  output logic      [31:0] prdata,            // apb read data
  output logic             pslverr,           // apb error
  input  wire logic        tx_start,          // transmit start pulse
  input  wire logic        last_byte,         // last byte handed to baseband
  input  wire logic        tx_end,            // baseband transmit end pulse
  input  wire logic        baseband_bw40,     // baseband set to 40 MHz
  input  wire logic [15:0] txop_rem_us,       // remaining opportunity, us
  input  wire logic [15:0] rx_rdg_dur_us,     // duration of received grant frame
  input  wire logic        want_40,           // 40 MHz transmission requested
  input  wire logic        ext_cca_busy,      // extension channel busy
  input  wire logic        ext_backoff_done,  // extension backoff finished
  input  wire logic [4:0]  trunc_events,      // truncation causes
  input  wire logic [15:0] frame_len,         // frame length in bytes
  input  wire logic [7:0]  rts_tries,         // protection attempts so far
  input  wire logic [31:0] frame_age_us,      // time the frame has queued
  input  wire logic        is_aggregate,      // frame is an aggregate
  input  wire logic [7:0]  retry_count,       // retries so far
  input  wire logic        cur_ht,            // current rate is high-throughput
  input  wire logic        cur_ofdm,          // legacy current rate is ofdm
  input  wire logic [3:0]  cur_rate,          // current rate index
  output logic             rf_txrx_line,      // rf transmit/receive line
  output logic             antenna_switch_line, // antenna switch
  output logic      [3:0]  amp_enable_line,   // amps: a0, g0, a1, g1
  output logic      [3:0]  lna_line,          // lnas: a0, g0, a1, g1
  output logic             converter_enable_line, // dac enable
  output logic             baseband_tx_enable, // baseband transmit enable
  output logic             upper_sub_band,    // 20 MHz frames in upper half
  output logic             high_band_pin_true, // high band pin
  output logic             high_band_pin_inverse, // its complement pin
  output logic             opportunity_lapse, // let opportunity lapse
  output logic             send_release_frame, // send release frame
  output logic             reverse_grant_usable, // received grant usable
  output logic             reverse_grant_allowed, // may set grant bit
  output logic             ext_defer,         // hold 40 MHz transmission
  output logic             ext_fallback_20,   // send at 20 MHz instead
  output logic             ext_sense_delayed, // delayed extension busy
  output logic             truncate_now,      // truncate opportunity
  output logic             protect_needed,    // protection exchange needed
  output logic             protect_retries_done, // protection retries used up
  output logic             frame_expired,     // lifetime ran out
  output logic             retries_done,      // stop retransmitting
  output logic      [3:0]  fallback_rate,     // next rate on retry
  output logic             fallback_ht,       // next rate is high-throughput
  output logic             fallback_ofdm,     // legacy next rate is ofdm
  output logic             fallback_stop      // fallback reached its floor
);

  typedef struct packed {
    logic [NREG-1:0][31:0] regs;
    seq_t                  st;
    logic [8:0]            cnt;
    logic [7:0]            qacc;
    logic [7:0]            uscnt;
    logic [7:0]            idle_us;
    logic [NCH-1:0]        on;
    logic                  txpe_done;
    logic                  pready;
    logic                  pslverr;
    logic [31:0]           prdata;
    logic                  rf;
    logic                  sw;
    logic [3:0]            amp;
    logic [3:0]            lna;
    logic                  dac;
    logic                  txpe;
    logic [19:0]           flags;
    logic [3:0]            fb_rate;
  } state_t;

  state_t s_q;
  state_t s_d;

  logic                  qtick;
  logic                  utick;
  logic [8:0]            qsum;
  logic                  hit;
  logic                  stat;
  logic [3:0]            idx;
  logic [NCH-1:0][7:0]   on_dly;
  logic [NCH-1:0][7:0]   off_dly;
  logic [31:0]           pin;
  logic [31:0]           thr;
  logic [31:0]           ctl;
  logic [31:0]           rty;
  logic [31:0]           tab;
  logic [3:0]            fbk;
  logic [7:0]            rlim;
  logic                  expired;

  //////////////////////////////////////////////////////////////////////////////
  always_comb begin
    s_d = s_q;
    pin = s_q.regs[R_PIN];
    thr = s_q.regs[R_THR];
    ctl = s_q.regs[R_CTRL];
    rty = s_q.regs[R_RTY];
    // quarter-us tick: 62/63 cycles alternating, exact on average
    // tick phase is free, so a delay of n units ends n-1 to n units after the event
    qsum = 9'(s_q.qacc) + 9'(CLK_NS);
    qtick = qsum >= 9'(QUARTER_NS);
    s_d.qacc = qtick ? 8'(qsum - 9'(QUARTER_NS)) : 8'(qsum);
    utick = s_q.uscnt == 8'(US_CYC - 1);
    s_d.uscnt = utick ? 8'h00 : s_q.uscnt + 8'h01;

    // apb: one wait state, write lands on the completing edge
    hit = 1'b0;
    idx = 4'h0;
    stat = paddr == STAT_OFF;
    for (int i = 0; i < NREG; i++) begin
      if (paddr == REG_OFF[i]) begin
        hit = 1'b1;
        idx = 4'(i);
      end
    end
    if (psel && penable && s_q.pready) begin
      s_d.pready = 1'b0;
      s_d.pslverr = 1'b0;
      s_d.prdata = 32'h00000000;
      // reserved and read-only positions keep their stored value
      if (pwrite && hit) begin
        s_d.regs[idx] = (s_q.regs[idx] & ~WMASK[idx]) | (pwdata & WMASK[idx]);
      end
    end else if (psel && penable) begin
      s_d.pready = 1'b1;
      s_d.pslverr = !(hit || stat) || (stat && pwrite);
      if (hit && !pwrite) begin
        s_d.prdata = s_q.regs[idx];
      end else if (stat && !pwrite) begin
        // status: sequencer state, enable-done flag, six on-bits
        s_d.prdata = {22'h000000, s_q.st, s_q.txpe_done, s_q.on, 1'b0};
      end else begin
        s_d.prdata = 32'h00000000;
      end
    end

    //////////////////////////////////////////////////////////////////////////////
    // front-end sequencer
    on_dly = {s_q.regs[R_SW0][7:0], s_q.regs[R_SW2][31:24], s_q.regs[R_SW2][15:8],
              s_q.regs[R_SW0][15:8], s_q.regs[R_SW0][23:16], s_q.regs[R_SW0][31:24]};
    off_dly = {8'h00, s_q.regs[R_SW2][23:16], s_q.regs[R_SW2][7:0],
               s_q.regs[R_SW1][7:0], s_q.regs[R_SW1][15:8], s_q.regs[R_SW1][23:16]};
    if (qtick && s_q.cnt != 9'h1FF) begin
      s_d.cnt = s_q.cnt + 9'h001;
    end
    // an end event before a line's on delay ran out leaves that line off
    case (s_q.st)
      SEQ_IDLE: begin
        if (tx_start) begin
          s_d.st = SEQ_ON;
          s_d.cnt = 9'h000;
          s_d.txpe_done = 1'b0;
        end
      end
      SEQ_ON: begin
        for (int c = 0; c < NCH; c++) begin
          if (s_q.cnt >= {1'b0, on_dly[c]}) begin
            s_d.on[c] = 1'b1;
          end
        end
        if (s_q.txpe_done) begin
          s_d.on[CH_TXPE] = 1'b0;
        end
        if (last_byte) begin
          s_d.on[CH_TXPE] = 1'b0;
          s_d.txpe_done = 1'b1;
        end
        if (tx_end) begin
          s_d.st = SEQ_OFF;
          s_d.cnt = 9'h000;
        end
      end
      SEQ_OFF: begin
        for (int c = 0; c < CH_TXPE; c++) begin
          if (s_q.cnt >= {1'b0, off_dly[c]}) begin
            s_d.on[c] = 1'b0;
          end
        end
        s_d.on[CH_TXPE] = 1'b0;
        if (s_q.on[CH_LNA:CH_RF] == '0) begin
          s_d.st = SEQ_IDLE;
        end
      end
      default: begin
        s_d.st = SEQ_IDLE;
        s_d.on = '0;
      end
    endcase

    // pin levels: enable gates, polarity chooses the active level; dac and txpe lines pass through ungated
    s_d.rf = pin[RF_EN_BIT] & (pin[RF_POL_BIT] ? s_q.on[CH_RF] : ~s_q.on[CH_RF]);
    s_d.sw = pin[SW_EN_BIT] & (pin[SW_POL_BIT] ? s_q.on[CH_SW] : ~s_q.on[CH_SW]);
    s_d.amp = pin[3:0] & ({4{s_q.on[CH_PA]}} ^ pin[7:4]);
    s_d.lna = pin[11:8] & ({4{s_q.on[CH_LNA]}} ^ pin[15:12]);
    s_d.dac = s_q.on[CH_DAC];
    s_d.txpe = s_q.on[CH_TXPE];

    //////////////////////////////////////////////////////////////////////////////
    // opportunity, extension channel and protection decisions
    s_d.flags[0] = baseband_bw40 & s_q.regs[R_BAND][SUBBAND_BIT];
    s_d.flags[1] = s_q.regs[R_BAND][HB_TRUE_BIT];
    s_d.flags[2] = s_q.regs[R_BAND][HB_INV_BIT];
    s_d.flags[3] = txop_rem_us < 16'({thr[31:24], 5'h00});
    s_d.flags[4] = (thr[23:16] != RELEASE_OFF) && (txop_rem_us > 16'({thr[23:16], 5'h00}));
    s_d.flags[5] = rx_rdg_dur_us >= 16'({thr[15:8], 5'h00});
    s_d.flags[6] = txop_rem_us >= 16'({thr[7:0], 5'h00});
    s_d.flags[7] = want_40 & ctl[EXT_EN_BIT] & ext_cca_busy & (ctl[19:16] == 4'h0);
    s_d.flags[8] = want_40 & ctl[EXT_EN_BIT] & (ctl[19:16] != 4'h0)
                   & (ext_cca_busy | ~ext_backoff_done);
    // whole microseconds on a free-running tick: the delayed copy may
    // clear up to one microsecond before the programmed delay
    if (ext_cca_busy) begin
      s_d.idle_us = 8'h00;
    end else if (utick && s_q.idle_us != 8'hFF) begin
      s_d.idle_us = s_q.idle_us + 8'h01;
    end
    s_d.flags[9] = ext_cca_busy | (s_q.idle_us < ctl[15:8]);
    s_d.flags[10] = |(trunc_events & ctl[4:0]);
    s_d.flags[11] = frame_len > s_q.regs[R_RTS][23:8];
    s_d.flags[12] = rts_tries >= s_q.regs[R_RTS][7:0];
    expired = frame_age_us >= (32'h00000001 << (5'(LIFE_BASE) + {1'b0, s_q.regs[R_TMO][7:4]}));
    s_d.flags[13] = expired;
    rlim = (frame_len > {4'h0, rty[27:16]}) ? rty[15:8] : rty[7:0];
    if (is_aggregate ? rty[AGG_MODE_BIT] : rty[SGL_MODE_BIT]) begin
      s_d.flags[14] = expired;
    end else begin
      s_d.flags[14] = retry_count >= rlim;
    end

    // rate fallback
    if (cur_ht) begin
      tab = cur_rate[3] ? s_q.regs[R_HT1] : s_q.regs[R_HT0];
      fbk = 4'(tab >> {cur_rate[2:0], 2'b00});
    end else if (cur_ofdm) begin
      tab = s_q.regs[R_LG0];
      fbk = 4'(tab >> {cur_rate[2:0], 2'b00});
    end else begin
      tab = s_q.regs[R_LG1];
      fbk = 4'(tab >> {cur_rate[1:0], 2'b00});
    end
    s_d.fb_rate = rty[AUTOFB_BIT] ? fbk : cur_rate;
    s_d.flags[15] = cur_ht;
    s_d.flags[16] = !cur_ht && (rty[AUTOFB_BIT] ? fbk[3] : cur_ofdm);
    s_d.flags[17] = fbk == cur_rate;
    s_d.flags[19:18] = 2'b00;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
      s_q.regs <= REG_RST;
      s_q.st <= SEQ_IDLE;
      s_q.flags <= 20'h00004; // inverse pin starts high
    end else begin
      s_q <= s_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  assign pready = s_q.pready;
  assign prdata = s_q.prdata;
  assign pslverr = s_q.pslverr;
  assign rf_txrx_line = s_q.rf;
  assign antenna_switch_line = s_q.sw;
  assign amp_enable_line = s_q.amp;
  assign lna_line = s_q.lna;
  assign converter_enable_line = s_q.dac;
  assign baseband_tx_enable = s_q.txpe;
  assign upper_sub_band = s_q.flags[0];
  assign high_band_pin_true = s_q.flags[1];
  assign high_band_pin_inverse = s_q.flags[2];
  assign opportunity_lapse = s_q.flags[3];
  assign send_release_frame = s_q.flags[4];
  assign reverse_grant_usable = s_q.flags[5];
  assign reverse_grant_allowed = s_q.flags[6];
  assign ext_defer = s_q.flags[7];
  assign ext_fallback_20 = s_q.flags[8];
  assign ext_sense_delayed = s_q.flags[9];
  assign truncate_now = s_q.flags[10];
  assign protect_needed = s_q.flags[11];
  assign protect_retries_done = s_q.flags[12];
  assign frame_expired = s_q.flags[13];
  assign retries_done = s_q.flags[14];
  assign fallback_rate = s_q.fb_rate;
  assign fallback_ht = s_q.flags[15];
  assign fallback_ofdm = s_q.flags[16];
  assign fallback_stop = s_q.flags[17];

  //////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  apb_wait_state_a: assert property (psel && penable && !pready |=> pready)
    else $error("apb access not answered after one wait state");
  reserved_bits_a: assert property ((s_q.regs[R_LINK] & ~(WMASK[R_LINK] | LINK_RO)) == '0
    && (s_q.regs[R_BAND] & ~WMASK[R_BAND]) == '0)
    else $error("reserved register bits not zero");
  amp_gate_a: assert property (!s_q.regs[R_PIN][0] |=> !amp_enable_line[0])
    else $error("disabled amplifier pin driven");
  sub_band_a: assert property (!baseband_bw40 |=> !upper_sub_band)
    else $error("sub-band choice used outside 40 MHz");
  band_pins_a: assert property (##1 high_band_pin_true == $past(s_q.regs[R_BAND][HB_TRUE_BIT]))
    else $error("high band pin does not follow register");
  rise_delay_a: assert property ($rose(s_q.on[CH_RF]) |-> $past(s_q.st) == SEQ_ON
    && $past(s_q.cnt) >= {1'b0, $past(s_q.regs[R_SW0][31:24])})
    else $error("rf line rose before its delay");
  fall_delay_a: assert property ($fell(s_q.on[CH_PA]) && $past(s_q.st) == SEQ_OFF
    |-> $past(s_q.cnt) >= {1'b0, $past(s_q.regs[R_SW1][7:0])})
    else $error("amp line fell before its delay");
  txpe_drop_a: assert property (s_q.st == SEQ_ON && last_byte |=> !s_q.on[CH_TXPE]
    ##1 !baseband_tx_enable)
    else $error("baseband enable held after last byte");
  release_off_a: assert property (s_q.regs[R_THR][23:16] == RELEASE_OFF |=> !send_release_frame)
    else $error("release frame requested while disabled");
  lapse_a: assert property (txop_rem_us < 16'({s_q.regs[R_THR][31:24], 5'h00})
    |=> opportunity_lapse)
    else $error("opportunity below limit not lapsed");
  ht_fallback_a: assert property (cur_ht |=> fallback_ht && !fallback_ofdm)
    else $error("high-throughput rate fell back to legacy");
  truncate_a: assert property (|(trunc_events & s_q.regs[R_CTRL][4:0]) |=> truncate_now)
    else $error("enabled truncation cause ignored");
  protect_len_a: assert property (frame_len > s_q.regs[R_RTS][23:8] |=> protect_needed)
    else $error("long frame left unprotected");
  txpe_off_a: assert property (s_q.st == SEQ_OFF |=> !s_q.on[CH_TXPE])
    else $error("baseband enable on after transmit end");
  band_inverse_a: assert property (##1 high_band_pin_inverse
    == $past(s_q.regs[R_BAND][HB_INV_BIT]))
    else $error("inverse band pin does not follow register");

  seq_walk_c: cover property (s_q.st == SEQ_ON ##[1:1000] s_q.st == SEQ_OFF
    ##[1:1000] s_q.st == SEQ_IDLE);
  apb_write_c: cover property (psel && penable && pready && pwrite);
  fallback_stop_c: cover property (fallback_stop && fallback_ht);
  lapse_c: cover property (opportunity_lapse && !send_release_frame);
  ext_fallback_c: cover property (ext_fallback_20 && !ext_defer);

endmodule : wlan_mac_tx_config
`default_nettype wire

// *** rtl/dummy_placeholder_none.sv ***
// intentionally minimal: no additional logic lives here
`timescale 1ns/1ns
`default_nettype none
`default_nettype wire

// *** verif/bb_model.sv ***
// partner model of the baseband side: frame start, last byte and end pulses
`timescale 1ns/1ns
`default_nettype none
module bb_model (
  input  wire logic pclk,      // clock
  output logic      tx_start,  // frame start pulse
  output logic      last_byte, // last byte handed over
  output logic      tx_end     // transmit end pulse
);
  initial {tx_start, last_byte, tx_end} = 3'b000;
  // one-cycle pulse on the chosen lines, launched just after an edge
  task automatic pulse(input logic [2:0] which);
    @(posedge pclk);
    {tx_start, last_byte, tx_end} <= which;
    @(posedge pclk);
    {tx_start, last_byte, tx_end} <= 3'b000;
  endtask : pulse
endmodule : bb_model
`default_nettype wire

// *** verif/test_wlan_mac_tx_config.sv ***
// self-checking bench of the transmit configuration block
`timescale 1ns/1ns
`default_nettype none
module test_wlan_mac_tx_config;
  import txcfg_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [15:0] paddr = '0, txop_rem_us = '0, rx_rdg_dur_us = '0, frame_len = '0;
  logic [31:0] pwdata = '0, frame_age_us = '0, prdata, q;
  logic baseband_bw40 = 1'b0, want_40 = 1'b0, ext_cca_busy = 1'b0, ext_backoff_done = 1'b0;
  logic is_aggregate = 1'b0, cur_ht = 1'b0, cur_ofdm = 1'b0, e;
  logic [4:0] trunc_events = '0;
  logic [7:0] rts_tries = '0, retry_count = '0;
  logic [3:0] cur_rate = '0, amp_enable_line, lna_line, fallback_rate;
  logic pready, pslverr, tx_start, last_byte, tx_end, rf_txrx_line, antenna_switch_line;
  logic converter_enable_line, baseband_tx_enable, upper_sub_band, high_band_pin_true;
  logic high_band_pin_inverse, opportunity_lapse, send_release_frame, reverse_grant_usable;
  logic reverse_grant_allowed, ext_defer, ext_fallback_20, ext_sense_delayed, truncate_now;
  logic protect_needed, protect_retries_done, frame_expired, retries_done;
  logic fallback_ht, fallback_ofdm, fallback_stop;
  int cyc = 0, t0 = 0, miscompares = 0, comparisons = 0;
  wire logic [5:0] lines = {ext_sense_delayed, converter_enable_line, baseband_tx_enable,
                            amp_enable_line[0], antenna_switch_line, rf_txrx_line};
  wlan_mac_tx_config dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr,
    .tx_start, .last_byte, .tx_end, .baseband_bw40, .txop_rem_us, .rx_rdg_dur_us, .want_40,
    .ext_cca_busy, .ext_backoff_done, .trunc_events, .frame_len, .rts_tries, .frame_age_us,
    .is_aggregate, .retry_count, .cur_ht, .cur_ofdm, .cur_rate, .rf_txrx_line,
    .antenna_switch_line, .amp_enable_line, .lna_line, .converter_enable_line,
    .baseband_tx_enable, .upper_sub_band, .high_band_pin_true, .high_band_pin_inverse,
    .opportunity_lapse, .send_release_frame, .reverse_grant_usable, .reverse_grant_allowed,
    .ext_defer, .ext_fallback_20, .ext_sense_delayed, .truncate_now, .protect_needed,
    .protect_retries_done, .frame_expired, .retries_done, .fallback_rate, .fallback_ht,
    .fallback_ofdm, .fallback_stop);
  bb_model bbm (.pclk, .tx_start, .last_byte, .tx_end);
  always #2 pclk = ~pclk;
  always @(posedge pclk) cyc <= cyc + 1;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic conclude;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : conclude
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    comparisons++;
    if (g !== x) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, g, x);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    {q, e} = {prdata, pslverr};
    {psel, penable} <= 2'b00;
    if (n >= 20) begin
      miscompares++;
      conclude();
    end
  endtask : apb
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [15:0] a, input logic [31:0] x, input logic xe);
    apb(1'b0, a, 32'h0);
    chk(q, x);
    chk(e, xe);
  endtask : rd
  task automatic settle;
    repeat (2) @(posedge pclk);
    #1;
  endtask : settle
  // waits for a line to reach v at the d-th quarter-us tick after t0; tick phase is free
  task automatic measure(input int w, input logic v, input int d);
    while (lines[w] !== v && cyc - t0 <= d * 63 + 3) begin
      @(posedge pclk);
      #1;
    end
    chk(cyc - t0 >= (d - 1) * 62 + 2 && cyc - t0 <= d * 63 + 3, 1'b1);
    if (lines[w] !== v) conclude();
  endtask : measure
  task automatic dec(input logic [15:0] rem, input logic [15:0] rx, input logic [3:0] x);
    @(posedge pclk);
    {txop_rem_us, rx_rdg_dur_us} <= {rem, rx};
    settle();
    chk({opportunity_lapse, send_release_frame, reverse_grant_usable, reverse_grant_allowed}, x);
  endtask : dec
  task automatic ret(input logic agg, input logic [15:0] len, input logic [7:0] n,
                     input logic [31:0] age, input logic [1:0] x);
    @(posedge pclk);
    {is_aggregate, frame_len, retry_count, frame_age_us} <= {agg, len, n, age};
    settle();
    chk({frame_expired, retries_done}, x);
  endtask : ret
  task automatic fb(input logic ht, input logic ofdm, input logic [3:0] r, input logic [6:0] x);
    @(posedge pclk);
    {cur_ht, cur_ofdm, cur_rate} <= {ht, ofdm, r};
    settle();
    chk({fallback_rate, fallback_ht, fallback_ofdm, fallback_stop}, x);
  endtask : fb
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    settle();
    chk({high_band_pin_true, high_band_pin_inverse}, 2'b01);
    for (int i = 0; i < NREG; i++) begin
      rd(REG_OFF[i], REG_RST[i], 1'b0);
      wr(REG_OFF[i], 32'hFFFFFFFF);
    end
    for (int i = 0; i < NREG; i++) begin
      rd(REG_OFF[i], WMASK[i] | (REG_RST[i] & ~WMASK[i]), 1'b0);
      wr(REG_OFF[i], REG_RST[i]);
    end
    rd(16'h1300, 32'h0, 1'b1);
    apb(1'b1, STAT_OFF, 32'h1);
    chk(e, 1'b1);
    $display("registers done");
    wr(16'h132C, 32'h3);
    settle();
    chk({upper_sub_band, high_band_pin_true, high_band_pin_inverse}, 3'b010);
    @(posedge pclk);
    baseband_bw40 <= 1'b1;
    settle();
    chk(upper_sub_band, 1'b1);
    wr(16'h133C, 32'h02030104);
    dec(16'd63, 16'd31, 4'b1000);
    dec(16'd97, 16'd32, 4'b0110);
    dec(16'd128, 16'd32, 4'b0111);
    wr(16'h133C, 32'h00FF0000);
    dec(16'hFFFF, 16'd0, 4'b0011);
    $display("band and thresholds done");
    wr(16'h1340, 32'h000024BF);
    @(posedge pclk);
    {want_40, ext_cca_busy, ext_backoff_done, trunc_events} <= {3'b110, 5'h01};
    settle();
    chk({ext_defer, ext_fallback_20, truncate_now, ext_sense_delayed}, 4'b1011);
    wr(16'h1340, 32'h000102BE);
    @(posedge pclk);
    ext_cca_busy <= 1'b0;
    settle();
    chk({ext_defer, ext_fallback_20, truncate_now}, 3'b010);
    t0 = cyc;
    // 2 us of idle on a free-running us tick: clears within the second us
    while (lines[5] !== 1'b0 && cyc - t0 < 2 * US_CYC) begin
      @(posedge pclk);
      #1;
    end
    chk(cyc - t0 >= US_CYC && cyc - t0 < 2 * US_CYC, 1'b1);
    wr(16'h1344, 32'h00010007);
    @(posedge pclk);
    {frame_len, rts_tries} <= {16'h0101, 8'd6};
    settle();
    chk({protect_needed, protect_retries_done}, 2'b10);
    ret(1'b0, 16'h0100, 8'd6, 32'h0, 2'b00);
    chk({protect_needed, protect_retries_done}, 2'b00);
    ret(1'b1, 16'h0, 8'd0, 32'h3FFFF, 2'b00);
    ret(1'b1, 16'h0, 8'd0, 32'h40000, 2'b11);
    ret(1'b0, 16'hBB9, 8'd4, 32'h0, 2'b01);
    ret(1'b0, 16'hBB8, 8'd4, 32'h0, 2'b00);
    ret(1'b0, 16'hBB8, 8'd7, 32'h0, 2'b01);
    wr(16'h134C, 32'h6BB80407);
    fb(1'b1, 1'b0, 4'd5, {4'h4, 3'b100});
    fb(1'b1, 1'b1, 4'd0, {4'h0, 3'b101});
    fb(1'b1, 1'b0, 4'd9, {4'h8, 3'b100});
    fb(1'b0, 1'b1, 4'd3, {4'hA, 3'b010});
    fb(1'b0, 1'b0, 4'd2, {4'h1, 3'b000});
    $display("policy done");
    bbm.pulse(3'b100);
    #1 t0 = cyc;
    measure(0, 1'b0, 0);
    measure(1, 1'b0, 4);
    measure(3 + 1, 1'b1, 4);
    measure(2, 1'b1, 8);
    chk(amp_enable_line, 4'hF);
    measure(3, 1'b1, 12);
    chk(lna_line, 4'hF);
    bbm.pulse(3'b010);
    #1 t0 = cyc;
    measure(3, 1'b0, 0);
    bbm.pulse(3'b001);
    #1 t0 = cyc;
    measure(2, 1'b0, 8);
    measure(1, 1'b1, 8);
    measure(4, 1'b0, 8);
    measure(0, 1'b1, 12);
    wr(16'h1328, 32'h00050FFE);
    settle();
    chk(amp_enable_line, 4'hE);
    rd(STAT_OFF, 32'h00000080, 1'b0);
    $display("sequencer done");
    conclude();
  end
endmodule : test_wlan_mac_tx_config
`default_nettype wire
